/* dpa_adapter.sv */
// Contract
// - page bit picks output or direction register
// - control, direction, output writable; control, direction readable
// - direction bit one means output line
// - port A outputs drive output register bits
// - port A data read returns pin levels
// - port B read mixes outputs and pins
// - port B input lines are not driven
// - strobe A edge per bit 1 sets flag 7
// - aux A edge sets flag 6 while aux A is an input, bit 3 enables
// - flags set regardless of enables
// - port A data read clears both flags
// - port B flags and clearing mirror port A
// - irq A low on enabled flag
// - irq B low on enabled flag
// - irq outputs only pull low or release
// - select codes 00 A, 01 ctrlA, 10 B, 11 ctrlB
// - reset clears all registers but the aux levels (set high), lines inputs
// - aux A handshake, pulse, manual on read
// - aux B handshake, pulse, manual on write
`timescale 1ns/10ps
module dpa_adapter #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // processor bus
  input  wire logic              select_hi_0_in,
  input  wire logic              select_hi_1_in,
  input  wire logic              select_low_n_in,
  input  wire logic              reg_select_low_in,
  input  wire logic              reg_select_high_in,
  input  wire logic              read_write_in,
  input  wire logic [PORT_W-1:0] bus_data_in,
  output logic      [PORT_W-1:0] bus_data_out,
  output logic                   bus_data_oe_out,
  // port A
  input  wire logic [PORT_W-1:0] port_a_lines_in,
  output logic      [PORT_W-1:0] port_a_lines_out,
  output logic      [PORT_W-1:0] port_a_lines_oe_out,
  input  wire logic              port_a_strobe_in,
  input  wire logic              port_a_aux_line_in,
  output logic                   port_a_aux_line_out,
  output logic                   port_a_aux_line_oe_out,
  output logic                   port_a_irq_n_out,
  output logic                   port_a_irq_n_oe_out,
  // port B
  input  wire logic [PORT_W-1:0] port_b_lines_in,
  output logic      [PORT_W-1:0] port_b_lines_out,
  output logic      [PORT_W-1:0] port_b_lines_oe_out,
  input  wire logic              port_b_strobe_in,
  input  wire logic              port_b_aux_line_in,
  output logic                   port_b_aux_line_out,
  output logic                   port_b_aux_line_oe_out,
  output logic                   port_b_irq_n_out,
  output logic                   port_b_irq_n_oe_out
);

  if (PORT_W != dpa_pkg::DATA_W)
  begin : g_chk
    $error("dpa_adapter: PORT_W must equal the register width");
  end

  dpa_pkg::dpa_state_s q, d;

  logic              access, rd, wr;
  logic [1:0]        sel;
  logic              rd_a_data, rd_b_data, wr_b_data;
  logic [PORT_W-1:0] pins_a, pins_b;
  logic              strobe_a_edge, strobe_b_edge;
  logic              aux_a_edge, aux_b_edge, aux_a_set, aux_b_set;
  logic              aux_a_lvl, aux_b_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // control register update: flags set by edges win over a clear by read
  function automatic logic [7:0] ctrl_next(input logic [7:0] cur,
                                           input logic       wr_en,
                                           input logic [7:0] wdata,
                                           input logic       clr,
                                           input logic       set7,
                                           input logic       set6);
    logic [7:0] nxt;
    nxt = cur;
    if (wr_en)
    begin
      nxt = (cur & ~dpa_pkg::CTRL_WR_MASK) | (wdata & dpa_pkg::CTRL_WR_MASK);
    end
    if (clr)
    begin
      nxt[dpa_pkg::FLAG_STROBE_BIT] = 1'b0;
      nxt[dpa_pkg::FLAG_AUX_BIT]    = 1'b0;
    end
    if (set7)
    begin
      nxt[dpa_pkg::FLAG_STROBE_BIT] = 1'b1;
    end
    if (set6)
    begin
      nxt[dpa_pkg::FLAG_AUX_BIT] = 1'b1;
    end
    return nxt;
  endfunction : ctrl_next

  // request line of one port: either enabled flag pulls it
  function automatic logic irq_want(input logic [7:0] c);
    return (c[dpa_pkg::FLAG_STROBE_BIT] & c[dpa_pkg::STROBE_EN_BIT]) |
           (c[dpa_pkg::FLAG_AUX_BIT] & c[dpa_pkg::AUX_EN_BIT]);
  endfunction : irq_want

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detectors
  dpa_sync_edge #(.WIDTH(PORT_W)) u_pins_a (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (port_a_lines_in),
    .rise_in   (1'b0),
    .level_out (pins_a),
    .edge_out  ()
  );

  dpa_sync_edge #(.WIDTH(PORT_W)) u_pins_b (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (port_b_lines_in),
    .rise_in   (1'b0),
    .level_out (pins_b),
    .edge_out  ()
  );

  dpa_sync_edge #(.WIDTH(1)) u_strobe_a (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (port_a_strobe_in),
    .rise_in   (q.ctrl_a[dpa_pkg::STROBE_EDGE_BIT]),
    .level_out (),
    .edge_out  (strobe_a_edge)
  );

  dpa_sync_edge #(.WIDTH(1)) u_strobe_b (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (port_b_strobe_in),
    .rise_in   (q.ctrl_b[dpa_pkg::STROBE_EDGE_BIT]),
    .level_out (),
    .edge_out  (strobe_b_edge)
  );

  dpa_sync_edge #(.WIDTH(1)) u_aux_a (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (port_a_aux_line_in),
    .rise_in   (q.ctrl_a[dpa_pkg::AUX_EDGE_BIT]),
    .level_out (),
    .edge_out  (aux_a_edge)
  );

  dpa_sync_edge #(.WIDTH(1)) u_aux_b (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (port_b_aux_line_in),
    .rise_in   (q.ctrl_b[dpa_pkg::AUX_EDGE_BIT]),
    .level_out (),
    .edge_out  (aux_b_edge)
  );

  // the aux line only sets its flag while it is an input
  assign aux_a_set = aux_a_edge & ~q.ctrl_a[dpa_pkg::AUX_OUT_BIT];
  assign aux_b_set = aux_b_edge & ~q.ctrl_b[dpa_pkg::AUX_OUT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; an access is taken on every edge while selected
  assign access    = select_hi_0_in & select_hi_1_in & ~select_low_n_in;
  assign rd        = access & read_write_in;
  assign wr        = access & ~read_write_in;
  assign sel       = {reg_select_high_in, reg_select_low_in};
  assign rd_a_data = rd & (sel == dpa_pkg::SEL_PORT_A) & q.ctrl_a[dpa_pkg::PAGE_BIT];
  assign rd_b_data = rd & (sel == dpa_pkg::SEL_PORT_B) & q.ctrl_b[dpa_pkg::PAGE_BIT];
  assign wr_b_data = wr & (sel == dpa_pkg::SEL_PORT_B) & q.ctrl_b[dpa_pkg::PAGE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // register next state
  always_comb
  begin
    d          = q;
    d.rdata_oe = rd;
    d.pull_low = 1'b0;
    d.ctrl_a   = ctrl_next(q.ctrl_a, wr && sel == dpa_pkg::SEL_CTRL_A, bus_data_in,
                           rd_a_data, strobe_a_edge, aux_a_set);
    d.ctrl_b   = ctrl_next(q.ctrl_b, wr && sel == dpa_pkg::SEL_CTRL_B, bus_data_in,
                           rd_b_data, strobe_b_edge, aux_b_set);
    if (wr && sel == dpa_pkg::SEL_PORT_A)
    begin
      if (q.ctrl_a[dpa_pkg::PAGE_BIT])
      begin
        d.out_a = bus_data_in;
      end
      else
      begin
        d.dir_a = bus_data_in;
      end
    end
    if (wr && sel == dpa_pkg::SEL_PORT_B)
    begin
      if (q.ctrl_b[dpa_pkg::PAGE_BIT])
      begin
        d.out_b = bus_data_in;
      end
      else
      begin
        d.dir_b = bus_data_in;
      end
    end
    // read data is held from the last read; only the enable drops
    if (rd)
    begin
      unique case (sel)
        dpa_pkg::SEL_PORT_A:
        begin
          d.rdata = q.ctrl_a[dpa_pkg::PAGE_BIT] ? pins_a : q.dir_a;
        end
        dpa_pkg::SEL_CTRL_A:
        begin
          d.rdata = q.ctrl_a;
        end
        dpa_pkg::SEL_PORT_B:
        begin
          d.rdata = q.ctrl_b[dpa_pkg::PAGE_BIT] ?
                    ((q.out_b & q.dir_b) | (pins_b & ~q.dir_b)) : q.dir_b;
        end
        dpa_pkg::SEL_CTRL_B:
        begin
          d.rdata = q.ctrl_b;
        end
      endcase
    end
    // taken from the next flags so the request moves with the flag
    d.irq_a_oe = irq_want(d.ctrl_a);
    d.irq_b_oe = irq_want(d.ctrl_b);
  end

  // everything clears, which leaves every port line an input
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q          <= '0;
      q.ctrl_a   <= dpa_pkg::CTRL_RST;
      q.ctrl_b   <= dpa_pkg::CTRL_RST;
      q.dir_a    <= dpa_pkg::DIR_RST;
      q.dir_b    <= dpa_pkg::DIR_RST;
      q.out_a    <= dpa_pkg::OUT_RST;
      q.out_b    <= dpa_pkg::OUT_RST;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auxiliary line outputs
  dpa_aux_out u_aux_out_a (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .mode_in        (q.ctrl_a[dpa_pkg::AUX_OUT_BIT:dpa_pkg::AUX_EN_BIT]),
    .strobe_edge_in (strobe_a_edge),
    .trigger_in     (rd_a_data),
    .aux_out        (aux_a_lvl)
  );

  dpa_aux_out u_aux_out_b (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .mode_in        (q.ctrl_b[dpa_pkg::AUX_OUT_BIT:dpa_pkg::AUX_EN_BIT]),
    .strobe_edge_in (strobe_b_edge),
    .trigger_in     (wr_b_data),
    .aux_out        (aux_b_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers; both ports drive exactly their output lines
  assign bus_data_out           = q.rdata;
  assign bus_data_oe_out        = q.rdata_oe;
  assign port_a_lines_out       = q.out_a;
  assign port_a_lines_oe_out    = q.dir_a;
  assign port_b_lines_out       = q.out_b;
  assign port_b_lines_oe_out    = q.dir_b;
  assign port_a_aux_line_out    = aux_a_lvl;
  assign port_a_aux_line_oe_out = q.ctrl_a[dpa_pkg::AUX_OUT_BIT];
  assign port_b_aux_line_out    = aux_b_lvl;
  assign port_b_aux_line_oe_out = q.ctrl_b[dpa_pkg::AUX_OUT_BIT];
  // open drain: the level is always low, only the enable moves
  assign port_a_irq_n_out       = q.pull_low;
  assign port_a_irq_n_oe_out    = q.irq_a_oe;
  assign port_b_irq_n_out       = q.pull_low;
  assign port_b_irq_n_oe_out    = q.irq_b_oe;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_b_pulse_low;
    !port_b_aux_line_out ##1 port_b_aux_line_out;
  endsequence

  sequence s_a_pulse_low;
    !port_a_aux_line_out ##1 port_a_aux_line_out;
  endsequence

  property p_irq_a;
    port_a_irq_n_oe_out == irq_want(q.ctrl_a) && !port_a_irq_n_out;
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq A disagrees with flags");

  property p_irq_b;
    port_b_irq_n_oe_out == irq_want(q.ctrl_b) && !port_b_irq_n_out;
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("irq B disagrees with flags");

  property p_read_a_clears;
    rd_a_data && !strobe_a_edge && !aux_a_set |=> q.ctrl_a[7:6] == 2'h0;
  endproperty
  a_read_a_clears: assert property (p_read_a_clears) else $error("A flags not cleared");

  property p_read_b_clears;
    rd_b_data && !strobe_b_edge && !aux_b_set |=> q.ctrl_b[7:6] == 2'h0;
  endproperty
  a_read_b_clears: assert property (p_read_b_clears) else $error("B flags not cleared");

  property p_strobe_sets;
    strobe_a_edge |=> q.ctrl_a[dpa_pkg::FLAG_STROBE_BIT];
  endproperty
  a_strobe_sets: assert property (p_strobe_sets) else $error("strobe A flag lost");

  property p_aux_sets;
    aux_a_edge && !q.ctrl_a[dpa_pkg::AUX_OUT_BIT] |=> q.ctrl_a[dpa_pkg::FLAG_AUX_BIT];
  endproperty
  a_aux_sets: assert property (p_aux_sets) else $error("aux A flag lost");

  property p_dir_write;
    wr && sel == dpa_pkg::SEL_PORT_A && !q.ctrl_a[dpa_pkg::PAGE_BIT]
      |=> port_a_lines_oe_out == $past(bus_data_in) && $stable(port_a_lines_out);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction A write wrong");

  property p_read_a_pins;
    rd_a_data |=> bus_data_oe_out && bus_data_out == $past(pins_a);
  endproperty
  a_read_a_pins: assert property (p_read_a_pins) else $error("port A read not pins");

  property p_read_b_mix;
    rd_b_data |=> bus_data_out == (($past(q.out_b) & $past(q.dir_b)) |
                                   ($past(pins_b) & ~$past(q.dir_b)));
  endproperty
  a_read_b_mix: assert property (p_read_b_mix) else $error("port B read wrong");

  property p_b_pulse;
    wr_b_data && q.ctrl_b[5:3] == dpa_pkg::AUX_PULSE ##1 q.ctrl_b[5:3] == dpa_pkg::AUX_PULSE
      && !wr_b_data |-> s_b_pulse_low;
  endproperty
  a_b_pulse: assert property (p_b_pulse) else $error("aux B pulse wrong");

  property p_a_pulse;
    rd_a_data && q.ctrl_a[5:3] == dpa_pkg::AUX_PULSE ##1 q.ctrl_a[5:3] == dpa_pkg::AUX_PULSE
      && !rd_a_data |-> s_a_pulse_low;
  endproperty
  a_a_pulse: assert property (p_a_pulse) else $error("aux A pulse wrong");

endmodule : dpa_adapter

/* dpa_aux_out.sv */
`timescale 1ns/10ps
module dpa_aux_out (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // control bits 5..3 and events
  input  wire logic [2:0] mode_in,
  input  wire logic       strobe_edge_in,
  input  wire logic       trigger_in,
  // driven level of the auxiliary line
  output logic            aux_out
);

  typedef struct packed {
    logic level;
  } dpa_aux_s;

  dpa_aux_s q, d;

  ////////////////////////////////////////////////////////////////////////////
  // output modes; codes 0xx are input mode and keep the line parked high
  always_comb
  begin
    d = q;
    unique case (mode_in)
      dpa_pkg::AUX_HSHAKE:
      begin
        // the peripheral's strobe wins over a same-cycle trigger
        if (strobe_edge_in)
        begin
          d.level = 1'b1;
        end
        else if (trigger_in)
        begin
          d.level = 1'b0;
        end
      end
      dpa_pkg::AUX_PULSE:
      begin
        d.level = ~trigger_in;
      end
      dpa_pkg::AUX_LOW:
      begin
        d.level = 1'b0;
      end
      dpa_pkg::AUX_HIGH:
      begin
        d.level = 1'b1;
      end
      default:
      begin
        d.level = dpa_pkg::AUX_RST;
      end
    endcase
  end

  assign aux_out = q.level;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q.level <= dpa_pkg::AUX_RST;
    end
    else
    begin
      q <= d;
    end
  end

endmodule : dpa_aux_out

/* dpa_periph.sv */
`timescale 1ns/10ps
module dpa_periph (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // adapter side of the pins
  input  wire logic [7:0] a_out_in,
  input  wire logic [7:0] a_oe_in,
  input  wire logic [7:0] b_out_in,
  input  wire logic [7:0] b_oe_in,
  input  wire logic       a_aux_in,
  input  wire logic       a_aux_oe_in,
  input  wire logic       b_aux_in,
  input  wire logic       b_aux_oe_in,
  input  wire logic       a_irq_oe_in,
  input  wire logic       b_irq_oe_in,
  // levels the peripheral drives itself
  input  wire logic [7:0] a_drv_in,
  input  wire logic [7:0] a_drv_en_in,
  input  wire logic [7:0] b_drv_in,
  input  wire logic [7:0] b_drv_en_in,
  input  wire logic       a_aux_drv_in,
  input  wire logic       b_aux_drv_in,
  // resolved wire levels
  output logic      [7:0] a_pins_out,
  output logic      [7:0] b_pins_out,
  output logic            a_aux_pins_out,
  output logic            b_aux_pins_out,
  output logic            irq_wire_n_out
);
  logic [7:0] b_last_q;

  ////////////////////////////////////////////////////////////////////////////
  // port a keeps its pull-ups, so an undriven line floats high
  assign a_pins_out = (a_oe_in & a_out_in) | (~a_oe_in & (~a_drv_en_in | a_drv_in));
  // port b has no pull: a floating line flips every cycle to expose stale reads
  assign b_pins_out = (b_oe_in & b_out_in)
                    | (~b_oe_in & ((b_drv_en_in & b_drv_in) | (~b_drv_en_in & ~b_last_q)));
  // control line 2 resolves between adapter and peripheral
  assign a_aux_pins_out = a_aux_oe_in ? a_aux_in : a_aux_drv_in;
  assign b_aux_pins_out = b_aux_oe_in ? b_aux_in : b_aux_drv_in;
  // shared pulled-up request wire, either open drain pulls it low
  assign irq_wire_n_out = ~(a_irq_oe_in | b_irq_oe_in);

  // remember the last level of port b
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      b_last_q <= 8'h00;
    else
      b_last_q <= b_pins_out;
  end
endmodule : dpa_periph

/* dpa_pkg.sv */
package dpa_pkg;

  // data and port width
  localparam int DATA_W = 8;

  // register select codes
  localparam logic [1:0] SEL_PORT_A = 2'h0;
  localparam logic [1:0] SEL_CTRL_A = 2'h1;
  localparam logic [1:0] SEL_PORT_B = 2'h2;
  localparam logic [1:0] SEL_CTRL_B = 2'h3;

  // control register field positions
  localparam int STROBE_EN_BIT   = 0;
  localparam int STROBE_EDGE_BIT = 1;
  localparam int PAGE_BIT        = 2;
  localparam int AUX_EN_BIT      = 3;
  localparam int AUX_EDGE_BIT    = 4;
  localparam int AUX_OUT_BIT     = 5;
  localparam int FLAG_AUX_BIT    = 6;
  localparam int FLAG_STROBE_BIT = 7;

  // writable part of a control register; the two flags are read only
  localparam logic [7:0] CTRL_WR_MASK = 8'h3f;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'h00;
  localparam logic [7:0] OUT_RST  = 8'h00;
  localparam logic       AUX_RST  = 1'h1;

  // output modes of the auxiliary line (control bits 5..3)
  typedef enum logic [2:0] {
    AUX_HSHAKE = 3'b100,
    AUX_PULSE  = 3'b101,
    AUX_LOW    = 3'b110,
    AUX_HIGH   = 3'b111
  } dpa_aux_mode_e;

  // complete register state of the adapter
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] out_a;
    logic [7:0] out_b;
    logic [7:0] rdata;
    logic       rdata_oe;
    logic       irq_a_oe;
    logic       irq_b_oe;
    logic       pull_low;
  } dpa_state_s;

endpackage : dpa_pkg

/* dpa_sync_edge.sv */
`timescale 1ns/10ps
module dpa_sync_edge #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // asynchronous lines and edge choice
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic             rise_in,
  // synchronised level and one-cycle edge pulse
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] edge_out
);

  if (WIDTH < 1)
  begin : g_chk
    $error("dpa_sync_edge: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;
    logic [1:0]       warm;
  } dpa_sync_s;

  dpa_sync_s q, d;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser; meta is read by stable only
  always_comb
  begin
    d        = q;
    d.meta   = async_in;
    d.stable = q.meta;
    d.prev   = q.stable;
    if (q.warm != 2'h3)
    begin
      d.warm = q.warm + 2'h1;
    end
  end

  // edges are masked until the pipe has filled, so a line held high
  // through reset does not fake a rising edge
  always_comb
  begin
    level_out = q.stable;
    edge_out  = '0;
    if (q.warm == 2'h3)
    begin
      edge_out = rise_in ? (q.stable & ~q.prev) : (~q.stable & q.prev);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule : dpa_sync_edge

/* dual_port_peripheral_adapter_test.sv */
`timescale 1ns/10ps
module dual_port_peripheral_adapter_test;
  // one row: register, value written, value read back
  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] wd;
    logic [7:0] exp;
  } dpa_row_s;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cs0 = 1'b0, cs1 = 1'b0, cs2_n = 1'b1, rw = 1'b1;
  logic [1:0] rs = 2'h0;
  logic [7:0] wd = 8'h00, bus_d, bus_oe8, a_out, a_oe, b_out, b_oe, a_pin, b_pin, v;
  logic       bus_oe, a_stb = 1'b1, b_stb = 1'b1, a_aux_d = 1'b1, b_aux_d = 1'b1;
  logic       a_aux, a_aux_oe, b_aux, b_aux_oe, a_irq, a_irq_oe, b_irq, b_irq_oe;
  logic       a_aux_pin, b_aux_pin, irq_w;
  int         error_cnt = 0, check_count = 0, cyc = 0;
  dpa_row_s   rows [7] = '{
    '{dpa_pkg::SEL_CTRL_A, 8'hc0, 8'h00}, '{dpa_pkg::SEL_CTRL_B, 8'hff, 8'h3f},
    '{dpa_pkg::SEL_CTRL_B, 8'h00, 8'h00}, '{dpa_pkg::SEL_PORT_A, 8'h5a, 8'h5a},
    '{dpa_pkg::SEL_PORT_B, 8'hf0, 8'hf0}, '{dpa_pkg::SEL_CTRL_A, 8'h04, 8'h04},
    '{dpa_pkg::SEL_CTRL_B, 8'h04, 8'h04}};

  ////////////////////////////////////////////////////////////////////////////
  dpa_adapter dut (.clk_in(clk), .rst_in(rst), .select_hi_0_in(cs0), .select_hi_1_in(cs1),
    .select_low_n_in(cs2_n), .reg_select_low_in(rs[0]), .reg_select_high_in(rs[1]),
    .read_write_in(rw), .bus_data_in(wd), .bus_data_out(bus_d), .bus_data_oe_out(bus_oe),
    .port_a_lines_in(a_pin), .port_a_lines_out(a_out), .port_a_lines_oe_out(a_oe),
    .port_a_strobe_in(a_stb), .port_a_aux_line_in(a_aux_pin), .port_a_aux_line_out(a_aux),
    .port_a_aux_line_oe_out(a_aux_oe), .port_a_irq_n_out(a_irq), .port_a_irq_n_oe_out(a_irq_oe),
    .port_b_lines_in(b_pin), .port_b_lines_out(b_out), .port_b_lines_oe_out(b_oe),
    .port_b_strobe_in(b_stb), .port_b_aux_line_in(b_aux_pin), .port_b_aux_line_out(b_aux),
    .port_b_aux_line_oe_out(b_aux_oe), .port_b_irq_n_out(b_irq), .port_b_irq_n_oe_out(b_irq_oe));

  dpa_periph far (.clk_in(clk), .rst_in(rst), .a_out_in(a_out), .a_oe_in(a_oe),
    .b_out_in(b_out), .b_oe_in(b_oe), .a_aux_in(a_aux), .a_aux_oe_in(a_aux_oe), .b_aux_in(b_aux),
    .b_aux_oe_in(b_aux_oe), .a_irq_oe_in(a_irq_oe), .b_irq_oe_in(b_irq_oe), .a_drv_in(8'h00),
    .a_drv_en_in(8'hff), .b_drv_in(8'h05), .b_drv_en_in(8'h0f), .a_aux_drv_in(a_aux_d),
    .b_aux_drv_in(b_aux_d), .a_pins_out(a_pin), .b_pins_out(b_pin),
    .a_aux_pins_out(a_aux_pin), .b_aux_pins_out(b_aux_pin), .irq_wire_n_out(irq_w));

  // 40 mhz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // hang guard, a few hundred cycles are expected
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  // one bus cycle: select held for exactly one taken edge
  task automatic access(input logic r, input logic [1:0] s, input logic [7:0] d,
                        input logic ok, output logic [7:0] q);
    @(posedge clk);
    cs0   <= 1'b1;
    cs1   <= ok;
    cs2_n <= 1'b0;
    rs    <= s;
    rw    <= r;
    wd    <= d;
    @(posedge clk);
    cs0   <= 1'b0;
    cs1   <= 1'b0;
    cs2_n <= 1'b1;
    #1;
    q = bus_d;
  endtask : access

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    access(1'b0, s, d, 1'b1, v);
  endtask : wr

  // read and compare; the data must come with the enable
  task automatic rd_chk(input logic [1:0] s, input logic [7:0] e);
    access(1'b1, s, 8'h00, 1'b1, v);
    bus_oe8 = {7'h00, bus_oe};
    chk(bus_oe8, 8'h01);
    chk(v, e);
  endtask : rd_chk

  // edges pass two synchronisers and the flag stage
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask : settle

  // reset for 16 cycles, outputs checked while it is held
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    #1;
    chk(a_oe | b_oe, 8'h00);
    chk({4'h0, a_aux_oe, b_aux_oe, a_irq_oe, b_irq_oe}, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(dpa_pkg::SEL_CTRL_A, 8'h00);
    rd_chk(dpa_pkg::SEL_CTRL_B, 8'h00);
    rd_chk(dpa_pkg::SEL_PORT_A, 8'h00);
    rd_chk(dpa_pkg::SEL_PORT_B, 8'h00);
  endtask : do_reset

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    // register table, page bit set last so data is reachable
    foreach (rows[i])
    begin
      wr(rows[i].sel, rows[i].wd);
      rd_chk(rows[i].sel, rows[i].exp);
    end
    // output and input lines of both ports
    wr(dpa_pkg::SEL_PORT_A, 8'hff);
    wr(dpa_pkg::SEL_PORT_B, 8'h3c);
    settle();
    chk(a_oe, 8'h5a);
    chk(a_pin, 8'h5a);
    chk(b_oe, 8'hf0);
    chk(b_out, 8'h3c);
    rd_chk(dpa_pkg::SEL_PORT_A, 8'h5a);
    rd_chk(dpa_pkg::SEL_PORT_B, 8'h35);
    // strobe a falling, enabled
    wr(dpa_pkg::SEL_CTRL_A, 8'h05);
    @(posedge clk);
    a_stb <= 1'b0;
    settle();
    chk({7'h00, irq_w}, 8'h00);
    chk({6'h00, a_irq, b_irq}, 8'h00);
    rd_chk(dpa_pkg::SEL_CTRL_A, 8'h85);
    rd_chk(dpa_pkg::SEL_PORT_A, 8'h5a);
    rd_chk(dpa_pkg::SEL_CTRL_A, 8'h05);
    chk({7'h00, a_irq_oe}, 8'h00);
    // flag still sets with the enable off
    wr(dpa_pkg::SEL_CTRL_A, 8'h04);
    @(posedge clk);
    a_stb <= 1'b1;
    settle();
    @(posedge clk);
    a_stb <= 1'b0;
    settle();
    chk({7'h00, a_irq_oe}, 8'h00);
    rd_chk(dpa_pkg::SEL_CTRL_A, 8'h84);
    rd_chk(dpa_pkg::SEL_PORT_A, 8'h5a);
    // rising edge selected
    wr(dpa_pkg::SEL_CTRL_A, 8'h07);
    @(posedge clk);
    a_stb <= 1'b1;
    settle();
    chk({7'h00, a_irq_oe}, 8'h01);
    rd_chk(dpa_pkg::SEL_CTRL_A, 8'h87);
    rd_chk(dpa_pkg::SEL_PORT_A, 8'h5a);
    // aux a input, rising, falling edge must be ignored
    wr(dpa_pkg::SEL_CTRL_A, 8'h1c);
    @(posedge clk);
    a_aux_d <= 1'b0;
    settle();
    rd_chk(dpa_pkg::SEL_CTRL_A, 8'h1c);
    @(posedge clk);
    a_aux_d <= 1'b1;
    settle();
    chk({7'h00, a_irq_oe}, 8'h01);
    rd_chk(dpa_pkg::SEL_CTRL_A, 8'h5c);
    rd_chk(dpa_pkg::SEL_PORT_A, 8'h5a);
    // port b mirror, both flags at once
    wr(dpa_pkg::SEL_CTRL_B, 8'h0d);
    @(posedge clk);
    b_stb   <= 1'b0;
    b_aux_d <= 1'b0;
    settle();
    chk({6'h00, a_irq_oe, b_irq_oe}, 8'h01);
    chk({7'h00, irq_w}, 8'h00);
    rd_chk(dpa_pkg::SEL_CTRL_B, 8'hcd);
    rd_chk(dpa_pkg::SEL_PORT_B, 8'h35);
    rd_chk(dpa_pkg::SEL_CTRL_B, 8'h0d);
    chk({7'h00, irq_w}, 8'h01);
    // aux a pulse after a data read
    wr(dpa_pkg::SEL_CTRL_A, 8'h2c);
    rd_chk(dpa_pkg::SEL_PORT_A, 8'h5a);
    chk({6'h00, a_aux_oe, a_aux}, 8'h02);
    @(posedge clk);
    #1;
    chk({7'h00, a_aux}, 8'h01);
    // aux a handshake: low on read, high on strobe edge
    wr(dpa_pkg::SEL_CTRL_A, 8'h24);
    rd_chk(dpa_pkg::SEL_PORT_A, 8'h5a);
    chk({7'h00, a_aux}, 8'h00);
    @(posedge clk);
    a_stb <= 1'b0;
    settle();
    chk({7'h00, a_aux}, 8'h01);
    // aux b pulse after a data write
    wr(dpa_pkg::SEL_CTRL_B, 8'h2c);
    wr(dpa_pkg::SEL_PORT_B, 8'h3c);
    chk({6'h00, b_aux_oe, b_aux}, 8'h02);
    @(posedge clk);
    #1;
    chk({7'h00, b_aux}, 8'h01);
    // aux b handshake, a rising strobe must not release it
    wr(dpa_pkg::SEL_CTRL_B, 8'h24);
    wr(dpa_pkg::SEL_PORT_B, 8'h3c);
    chk({7'h00, b_aux}, 8'h00);
    @(posedge clk);
    b_stb <= 1'b1;
    settle();
    chk({7'h00, b_aux}, 8'h00);
    @(posedge clk);
    b_stb <= 1'b0;
    settle();
    chk({7'h00, b_aux}, 8'h01);
    // manual levels on both ports
    for (int p = 0; p < 2; p++)
    begin
      wr(p ? dpa_pkg::SEL_CTRL_B : dpa_pkg::SEL_CTRL_A, 8'h34);
      @(posedge clk);
      #1;
      chk({7'h00, p ? b_aux : a_aux}, 8'h00);
      wr(p ? dpa_pkg::SEL_CTRL_B : dpa_pkg::SEL_CTRL_A, 8'h3c);
      @(posedge clk);
      #1;
      chk({7'h00, p ? b_aux : a_aux}, 8'h01);
    end
    // a write with one chip select missing is ignored; flag 7 stays from the handshake strobe
    access(1'b0, dpa_pkg::SEL_CTRL_A, 8'h01, 1'b0, v);
    rd_chk(dpa_pkg::SEL_CTRL_A, 8'hbc);
    // second reset in mid-run
    do_reset();
    wrap_up();
  end
endmodule : dual_port_peripheral_adapter_test
